// [include/acm_pkg.sv]
// package for the analog compare and trigger control block
// assumes one 40 MHz clock and a plain strobe register port
package acm_pkg;

  // ***************************************************************
  // register offsets
  // ***************************************************************
  localparam logic [2:0] ACM_OFF_DIS0  = 3'h0;
  localparam logic [2:0] ACM_OFF_DIS1  = 3'h1;
  localparam logic [2:0] ACM_OFF_MISC  = 3'h2;
  localparam logic [2:0] ACM_OFF_AUX   = 3'h3;
  localparam logic [2:0] ACM_OFF_CSR   = 3'h4;
  localparam logic [2:0] ACM_OFF_CONV  = 3'h5;

  // ***************************************************************
  // field positions and masks
  // ***************************************************************
  localparam int AUX_BIPOLAR   = 7;
  localparam int AUX_MUX_EN    = 6;
  localparam int AUX_LVL_HI    = 5;
  localparam int AUX_LVL_LO    = 4;
  localparam logic [7:0] AUX_WR_MASK  = 8'h77;
  localparam logic [7:0] DIS1_WR_MASK = 8'h70;
  localparam logic [7:0] MISC_WR_MASK = 8'h06;
  localparam int MISC_EXT_REF  = 2;
  localparam int MISC_INT_OUT  = 1;
  localparam int CSR_DISABLE   = 7;
  localparam int CSR_INT_REF   = 6;
  localparam int CSR_OUT       = 5;
  localparam int CSR_FLAG      = 4;
  localparam int CSR_IRQ_EN    = 3;
  localparam int CSR_CAPTURE   = 2;
  localparam logic [7:0] CSR_WR_MASK  = 8'hCF;
  localparam int CONV_ENABLE   = 0;
  localparam int CONV_AUTO     = 1;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [3:0] MUX_MAX_PIN  = 4'hA;
  localparam logic [1:0] REF_SRC_INT  = 2'h3;

  // ***************************************************************
  // encodings
  // ***************************************************************
  typedef enum logic [2:0] {
    TRG_FREE    = 3'h0,
    TRG_COMP    = 3'h1,
    TRG_EXT0    = 3'h2,
    TRG_CMPA    = 3'h3,
    TRG_OVF     = 3'h4,
    TRG_CMPB    = 3'h5,
    TRG_CAPT    = 3'h6,
    TRG_WDOG    = 3'h7
  } acm_trig_t;

  typedef enum logic [1:0] {
    IRQ_TOGGLE  = 2'h0,
    IRQ_RSVD    = 2'h1,
    IRQ_FALL    = 2'h2,
    IRQ_RISE    = 2'h3
  } acm_irq_mode_t;

  typedef enum logic [2:0] {
    ST_OFF      = 3'h1,
    ST_SINGLE   = 3'h2,
    ST_AUTO     = 3'h4
  } acm_state_t;

  // analog steering to the comparator and converter
  typedef struct packed {
    logic       pos_from_mux;
    logic [3:0] pos_channel;
    logic       neg_from_ref;
    logic [1:0] ref_level;
    logic       ext_ref_in;
    logic       int_ref_out;
    logic       comp_power_off;
    logic       bipolar;
  } acm_analog_t;

endpackage

// [src/acm_ctrl.sv]
// control logic around converter triggering and the analog comparator
// assumes synchronous inputs except comp_raw_i, one clock, sync reset
//
// What this block does
// RULE1: bipolar bit picks two-sided signed conversion
// RULE2: software writes zero to aux bit 3
// RULE3: trigger select ignored unless auto trigger set
// RULE4: rising selected flag starts a conversion
// RULE5: switching to set source gives trigger edge
// RULE6: switching to free running never triggers
// RULE7: trigger source encoding of eight sources
// RULE8: low disable bits kill pins 7 to 0
// RULE9: high disable bits kill pins 10 to 8
// RULE10: software writes zeros to reserved disable bits
// RULE11: misc bit 2 selects external reference pin
// RULE12: misc bit 1 drives internal reference out
// RULE13: comparator output high when positive is higher
// RULE14: mux enable with converter off picks channel
// RULE15: level bits choose internal reference level
// RULE16: level encoding full, half, quarter, eighth
// RULE17: reference select replaces the negative input
// RULE18: disable bit powers the comparator off
// RULE19: software clears enable before changing disable
// RULE20: comparator output synchronised, one to two cycles
// RULE21: flag set by mode event, cleared by one
// RULE22: mode encoding toggle, reserved, fall, rise
// RULE23: request only while enable bit set
// RULE24: capture link routes comparator to timer capture
// RULE25: request is flag and enable together
module acm_ctrl
  import acm_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic [2:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        comp_raw_i,
  input  wire logic [4:0]  input_channel_sel_i,
  input  wire logic [1:0]  reference_source_sel_i,
  input  wire logic        conv_done_flag_i,
  input  wire logic [7:1]  trig_flags_i,
  input  wire logic        conv_busy_i,
  input  wire logic        irq_ack_i,
  input  wire logic [10:0] pin_in_i,
  output logic [10:0] pin_in_o,
  output logic [10:0] input_buffer_off_o,
  output acm_analog_t analog_o,
  output logic        conv_start_o,
  output logic        capture_in_o,
  output logic        comp_irq_o
);

  // ***************************************************************
  // registers
  // ***************************************************************
  logic [7:0] analog_pin_input_disable_low;
  logic [2:0] analog_pin_input_disable_high;
  logic [7:0] misc_bits;
  logic [7:0] aux_bits;
  logic [7:0] csr_bits;
  logic       converter_enable;
  logic       auto_trigger_enable;
  logic       comp_meta;
  logic       comparator_output;
  logic       comparator_irq_flag;
  logic       trig_level_q;
  logic       comp_event;
  logic       trig_level;
  logic       trig_rise;
  logic       flag_clear;
  acm_state_t state;
  acm_state_t next_state;
  acm_trig_t  trig_sel;
  acm_irq_mode_t irq_mode;

  function automatic logic wr_to(input logic [2:0] off);
    wr_to = reg_wr_i && (reg_addr_i == off);
  endfunction

  assign trig_sel = acm_trig_t'(aux_bits[2:0]);
  assign irq_mode = acm_irq_mode_t'(csr_bits[1:0]);

  // ***************************************************************
  // register writes
  // ***************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      analog_pin_input_disable_low  <= RESET_BYTE;
      analog_pin_input_disable_high <= RESET_BYTE[2:0];
      misc_bits                     <= RESET_BYTE;
      aux_bits                      <= RESET_BYTE;
      csr_bits                      <= RESET_BYTE;
      converter_enable              <= 1'b0;
      auto_trigger_enable           <= 1'b0;
    end else begin
      if (wr_to(ACM_OFF_DIS0)) begin
        analog_pin_input_disable_low <= reg_wdata_i; // [RULE8]
      end
      if (wr_to(ACM_OFF_DIS1)) begin
        analog_pin_input_disable_high <= reg_wdata_i[6:4]; // [RULE9] [RULE10]
      end
      if (wr_to(ACM_OFF_MISC)) begin
        misc_bits <= reg_wdata_i & MISC_WR_MASK;
      end
      if (wr_to(ACM_OFF_AUX)) begin
        // bipolar kept writable, bit 3 forced zero
        aux_bits <= reg_wdata_i & (AUX_WR_MASK | 8'h80); // [RULE2]
      end
      if (wr_to(ACM_OFF_CSR)) begin
        csr_bits <= reg_wdata_i & CSR_WR_MASK;
      end
      if (wr_to(ACM_OFF_CONV)) begin
        converter_enable    <= reg_wdata_i[CONV_ENABLE];
        auto_trigger_enable <= reg_wdata_i[CONV_AUTO];
      end
    end
  end

  // ***************************************************************
  // comparator synchroniser
  // ***************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      comp_meta         <= 1'b0;
      comparator_output <= 1'b0;
    end else begin
      comp_meta         <= comp_raw_i;
      comparator_output <= comp_meta; // [RULE13] [RULE20]
    end
  end

  // ***************************************************************
  // comparator event and flag
  // ***************************************************************
  logic comp_prev;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      comp_prev <= 1'b0;
    end else begin
      comp_prev <= comparator_output;
    end
  end

  always_comb begin
    case (irq_mode) // [RULE22]
      IRQ_TOGGLE: comp_event = comparator_output ^ comp_prev;
      IRQ_FALL:   comp_event = comp_prev & ~comparator_output;
      IRQ_RISE:   comp_event = comparator_output & ~comp_prev;
      default:    comp_event = 1'b0;
    endcase
  end

  assign flag_clear = (wr_to(ACM_OFF_CSR) && reg_wdata_i[CSR_FLAG]) || irq_ack_i;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      comparator_irq_flag <= 1'b0;
    end else if (comp_event && !csr_bits[CSR_DISABLE]) begin
      comparator_irq_flag <= 1'b1; // [RULE21]
    end else if (flag_clear) begin
      comparator_irq_flag <= 1'b0; // [RULE21]
    end
  end

  // ***************************************************************
  // auto trigger selection and edge
  // ***************************************************************
  always_comb begin
    case (trig_sel) // [RULE7]
      TRG_FREE: trig_level = trig_level_q; // [RULE6]
      TRG_COMP: trig_level = comparator_irq_flag;
      default:  trig_level = trig_flags_i[trig_sel];
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      trig_level_q <= 1'b0;
    end else begin
      trig_level_q <= trig_level;
    end
  end

  // free running restarts on completion flag rising
  logic done_q;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= conv_done_flag_i;
    end
  end

  assign trig_rise = (trig_sel == TRG_FREE) ? (conv_done_flag_i & ~done_q)
                                            : (trig_level & ~trig_level_q); // [RULE4] [RULE5]

  // ***************************************************************
  // trigger state machine
  // ***************************************************************
  always_comb begin
    case (state)
      ST_OFF:    next_state = converter_enable ? ST_SINGLE : ST_OFF;
      ST_SINGLE: next_state = !converter_enable ? ST_OFF :
                              auto_trigger_enable ? ST_AUTO : ST_SINGLE;
      ST_AUTO:   next_state = !converter_enable ? ST_OFF :
                              auto_trigger_enable ? ST_AUTO : ST_SINGLE;
      default:   next_state = ST_OFF;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      conv_start_o <= 1'b0;
    end else begin
      // source ignored outside auto state
      conv_start_o <= (state == ST_AUTO) && auto_trigger_enable && converter_enable
                      && trig_rise && !conv_busy_i; // [RULE3] [RULE5]
    end
  end

  // ***************************************************************
  // pins, analog steering, request
  // ***************************************************************
  logic [10:0] disable_all;
  assign disable_all = {analog_pin_input_disable_high, analog_pin_input_disable_low};

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pin_in_o           <= 11'h000;
      input_buffer_off_o <= 11'h000;
      analog_o           <= '0;
      capture_in_o       <= 1'b0;
      comp_irq_o         <= 1'b0;
    end else begin
      pin_in_o           <= pin_in_i & ~disable_all; // [RULE8] [RULE9]
      input_buffer_off_o <= disable_all;
      analog_o.pos_from_mux <= aux_bits[AUX_MUX_EN] && !converter_enable
                               && (input_channel_sel_i[3:0] <= MUX_MAX_PIN)
                               && !input_channel_sel_i[4]; // [RULE14]
      analog_o.pos_channel  <= input_channel_sel_i[3:0];
      analog_o.neg_from_ref <= csr_bits[CSR_INT_REF]
                               && (reference_source_sel_i == REF_SRC_INT); // [RULE17]
      analog_o.ref_level    <= {aux_bits[AUX_LVL_HI], aux_bits[AUX_LVL_LO]}; // [RULE15]
      analog_o.ext_ref_in   <= misc_bits[MISC_EXT_REF]; // [RULE11]
      analog_o.int_ref_out  <= misc_bits[MISC_INT_OUT]; // [RULE12]
      analog_o.comp_power_off <= csr_bits[CSR_DISABLE]; // [RULE18]
      analog_o.bipolar      <= aux_bits[AUX_BIPOLAR]; // [RULE1]
      capture_in_o <= csr_bits[CSR_CAPTURE] & comparator_output; // [RULE24]
      comp_irq_o   <= comparator_irq_flag & csr_bits[CSR_IRQ_EN]; // [RULE23] [RULE25]
    end
  end

  // ***************************************************************
  // register reads
  // ***************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= RESET_BYTE;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        ACM_OFF_DIS0: reg_rdata_o <= analog_pin_input_disable_low;
        ACM_OFF_DIS1: reg_rdata_o <= {1'b0, analog_pin_input_disable_high, 4'h0};
        ACM_OFF_MISC: reg_rdata_o <= misc_bits;
        ACM_OFF_AUX:  reg_rdata_o <= aux_bits;
        ACM_OFF_CSR:  reg_rdata_o <= {csr_bits[7:6], comparator_output,
                                      comparator_irq_flag, csr_bits[3:0]};
        ACM_OFF_CONV: reg_rdata_o <= {6'h00, auto_trigger_enable, converter_enable};
        default:      reg_rdata_o <= RESET_BYTE;
      endcase
    end else begin
      reg_rdata_o <= RESET_BYTE;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  a_sync_latency: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $rose(comp_raw_i) ##1 comp_raw_i |=> comparator_output) // [RULE20]
    else $error("comparator output late");
  a_flag_set: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    comp_event && !csr_bits[CSR_DISABLE] |=> comparator_irq_flag) // [RULE21]
    else $error("flag not set on event");
  a_flag_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    irq_ack_i && !comp_event |=> !comparator_irq_flag) // [RULE21]
    else $error("flag not cleared");
  a_irq_gate: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    comp_irq_o |-> $past(comparator_irq_flag) && $past(csr_bits[CSR_IRQ_EN])) // [RULE23]
    else $error("request without flag and enable");
  a_no_auto_start: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !auto_trigger_enable |=> !conv_start_o) // [RULE3]
    else $error("start without auto trigger");
  a_free_switch: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (trig_sel == TRG_FREE) && !(conv_done_flag_i && !done_q) |=> !conv_start_o) // [RULE6]
    else $error("free running switch triggered");
  a_pin_mask: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    disable_all[0] |=> !pin_in_o[0]) // [RULE8]
    else $error("disabled pin reads one");
  a_high_pin_mask: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    disable_all[10] |=> !pin_in_o[10]) // [RULE9]
    else $error("disabled high pin reads one");
  a_capture_off: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !csr_bits[CSR_CAPTURE] |=> !capture_in_o) // [RULE24]
    else $error("capture linked while off");
  c_auto_start: cover property (@(posedge ref_clk_i) disable iff (srst_i) conv_start_o);
  c_comp_irq: cover property (@(posedge ref_clk_i) disable iff (srst_i) $rose(comp_irq_o));
  c_flag_clear: cover property (@(posedge ref_clk_i) disable iff (srst_i)
    $fell(comparator_irq_flag));

endmodule

// [testbench/acm_far_model.sv]
// far side model: comparator level, trigger flags, converter, port pins
// assumes one clock shared with the control block and sync reset
module acm_far_model (
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        conv_start_i,
  output logic             comp_raw_o,
  output logic [7:1]       trig_flags_o,
  output logic             conv_done_flag_o,
  output logic             conv_busy_o,
  output logic [10:0]      pin_in_o
);
  // ***************************************************************
  // source levels, changed just after a clock edge
  // ***************************************************************
  logic [1:0] busy_cnt;

  initial begin
    comp_raw_o       = 1'b0; // level is positive above negative
    trig_flags_o     = 7'h00; // flag index equals source code
    conv_done_flag_o = 1'b0;
    pin_in_o         = 11'h7FF;
  end

  task automatic set_raw(input logic v);
    @(posedge ref_clk_i);
    comp_raw_o <= v;
  endtask

  task automatic set_flag(input int idx, input logic v);
    @(posedge ref_clk_i);
    trig_flags_o[idx] <= v;
  endtask

  task automatic set_pins(input logic [10:0] v);
    @(posedge ref_clk_i);
    pin_in_o <= v;
  endtask

  task automatic set_done(input logic v);
    @(posedge ref_clk_i);
    conv_done_flag_o <= v;
  endtask

  // ***************************************************************
  // converter busy for three cycles after each start
  // ***************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      busy_cnt <= 2'h0;
    end else if (conv_start_i) begin
      busy_cnt <= 2'h3;
    end else if (busy_cnt != 2'h0) begin
      busy_cnt <= busy_cnt - 2'h1;
    end
  end

  assign conv_busy_o = (busy_cnt != 2'h0);
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the analog compare and trigger control block
// assumes the far side model and the package, 40 MHz clock
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module tb_top;
  import acm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ***************************************************************
  // signals and instances
  // ***************************************************************
  logic        ref_clk_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic [2:0]  reg_addr_i = 3'h0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i  = 1'b0;
  logic        reg_rd_i  = 1'b0;
  logic        irq_ack_i = 1'b0;
  logic [4:0]  input_channel_sel_i = 5'h0A;
  logic [1:0]  reference_source_sel_i = REF_SRC_INT;
  logic [7:0]  reg_rdata_o;
  logic        comp_raw_i;
  logic        conv_done_flag_i;
  logic [7:1]  trig_flags_i;
  logic        conv_busy_i;
  logic [10:0] pin_in_i;
  logic [10:0] pin_in_o;
  logic [10:0] input_buffer_off_o;
  acm_analog_t analog_o;
  logic        conv_start_o;
  logic        capture_in_o;
  logic        comp_irq_o;
  int          error_cnt = 0;
  int          n_checks  = 0;
  int          start_cnt = 0;
  int          cyc       = 0;
  logic [7:0]  d;

  acm_ctrl DUT (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .comp_raw_i(comp_raw_i),
    .input_channel_sel_i(input_channel_sel_i), .reference_source_sel_i(reference_source_sel_i),
    .conv_done_flag_i(conv_done_flag_i), .trig_flags_i(trig_flags_i),
    .conv_busy_i(conv_busy_i), .irq_ack_i(irq_ack_i), .pin_in_i(pin_in_i),
    .pin_in_o(pin_in_o), .input_buffer_off_o(input_buffer_off_o), .analog_o(analog_o),
    .conv_start_o(conv_start_o), .capture_in_o(capture_in_o), .comp_irq_o(comp_irq_o));

  acm_far_model u_far (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .conv_start_i(conv_start_o),
    .comp_raw_o(comp_raw_i), .trig_flags_o(trig_flags_i), .conv_done_flag_o(conv_done_flag_i),
    .conv_busy_o(conv_busy_i), .pin_in_o(pin_in_i));

  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  always @(negedge ref_clk_i) begin
    if (conv_start_o === 1'b1) begin
      start_cnt++;
    end
  end

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ***************************************************************
  // bus and helper tasks
  // ***************************************************************
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
    #1 v = reg_rdata_o;
  endtask

  task automatic expect_starts(input int n);
    repeat (6) @(posedge ref_clk_i);
    `CHK(start_cnt, n)
    start_cnt = 0;
  endtask

  task automatic finish_test();
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic test_reset_values();
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), d);
      `CHK(d, 8'h00)
    end
  endtask

  // all ones into registers 0 to 3 and 8'hC7 into the CSR: reserved bits must read back zero
  task automatic test_masks_and_pins();
    logic [7:0] wv[5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hC7};
    logic [7:0] ev[5] = '{8'hFF, 8'h70, 8'h06, 8'hF7, 8'hC7};
    for (int i = 0; i < 5; i++) begin
      wr(3'(i), wv[i]);
      rd(3'(i), d);
      `CHK(d, ev[i])
    end
    wr(3'h6, 8'hFF);
    rd(3'h6, d);
    `CHK(d, 8'h00)
    `CHK(pin_in_o, 11'h000)
    `CHK(input_buffer_off_o, 11'h7FF)
    `CHK(analog_o.bipolar, 1'b1)
    `CHK(analog_o.ext_ref_in, 1'b1)
    `CHK(analog_o.int_ref_out, 1'b1)
    wr(ACM_OFF_DIS0, 8'hA5);
    wr(ACM_OFF_DIS1, 8'h50);
    wr(ACM_OFF_MISC, 8'h00);
    wr(ACM_OFF_AUX, 8'h00);
    wr(ACM_OFF_CSR, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    `CHK(input_buffer_off_o, 11'h5A5)
    `CHK(pin_in_o, 11'h25A)
    `CHK(analog_o.bipolar, 1'b0)
    `CHK(analog_o.ext_ref_in, 1'b0)
    u_far.set_pins(11'h3C3);
    repeat (2) @(posedge ref_clk_i);
    `CHK(pin_in_o, 11'h242)
  endtask

  task automatic test_steering();
    wr(ACM_OFF_CONV, 8'h00);
    wr(ACM_OFF_AUX, 8'h60);
    wr(ACM_OFF_CSR, 8'hC0);
    repeat (2) @(posedge ref_clk_i);
    `CHK(analog_o.pos_from_mux, 1'b1)
    `CHK(analog_o.pos_channel, MUX_MAX_PIN)
    `CHK(analog_o.ref_level, 2'h2)
    `CHK(analog_o.neg_from_ref, 1'b1)
    `CHK(analog_o.comp_power_off, 1'b1)
    reference_source_sel_i <= 2'h1;
    input_channel_sel_i    <= 5'h0B;
    repeat (2) @(posedge ref_clk_i);
    `CHK(analog_o.neg_from_ref, 1'b0)
    `CHK(analog_o.pos_from_mux, 1'b0)
    reference_source_sel_i <= REF_SRC_INT;
    input_channel_sel_i    <= 5'h0A;
    wr(ACM_OFF_CONV, 8'h01);
    wr(ACM_OFF_CSR, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    `CHK(analog_o.pos_from_mux, 1'b0)
    `CHK(analog_o.neg_from_ref, 1'b0)
    `CHK(analog_o.comp_power_off, 1'b0)
    wr(ACM_OFF_CONV, 8'h00);
    wr(ACM_OFF_AUX, 8'h00);
  endtask

  task automatic test_irq_modes();
    acm_irq_mode_t md[3] = '{IRQ_TOGGLE, IRQ_FALL, IRQ_RISE};
    logic [1:0] m;
    logic       f;
    for (int i = 0; i < 3; i++) begin
      m = md[i];
      wr(ACM_OFF_CSR, {6'h00, m});
      wr(ACM_OFF_CSR, {4'h0, 1'b1, 1'b1, m});
      u_far.set_raw(1'b1);
      repeat (4) @(posedge ref_clk_i);
      `CHK(capture_in_o, 1'b1)
      f = (m != IRQ_FALL);
      rd(ACM_OFF_CSR, d);
      `CHK(d, {2'h0, 1'b1, f, 1'b1, 1'b1, m})
      `CHK(comp_irq_o, f)
      wr(ACM_OFF_CSR, {4'h1, 1'b1, 1'b1, m});
      u_far.set_raw(1'b0);
      repeat (3) @(posedge ref_clk_i);
      f = (m != IRQ_RISE);
      rd(ACM_OFF_CSR, d);
      `CHK(d, {2'h0, 1'b0, f, 1'b1, 1'b1, m})
      `CHK(comp_irq_o, f)
      @(posedge ref_clk_i);
      irq_ack_i <= 1'b1;
      @(posedge ref_clk_i);
      irq_ack_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      `CHK(comp_irq_o, 1'b0)
      wr(ACM_OFF_CSR, 8'h00);
    end
  endtask

  task automatic test_triggers();
    wr(ACM_OFF_CONV, 8'h01);
    wr(ACM_OFF_AUX, 8'h02);
    u_far.set_flag(2, 1'b1);
    expect_starts(0);
    u_far.set_flag(2, 1'b0);
    wr(ACM_OFF_CONV, 8'h03);
    repeat (2) @(posedge ref_clk_i);
    for (int s = 2; s < 8; s++) begin
      wr(ACM_OFF_AUX, 8'(s));
      u_far.set_flag(s, 1'b1);
      expect_starts(1);
      u_far.set_flag(s, 1'b0);
      expect_starts(0);
    end
    wr(ACM_OFF_AUX, 8'(TRG_EXT0));
    u_far.set_flag(4, 1'b1);
    expect_starts(0);
    wr(ACM_OFF_AUX, 8'(TRG_OVF));
    expect_starts(1);
    u_far.set_flag(4, 1'b0);
    u_far.set_done(1'b1);
    expect_starts(0);
    wr(ACM_OFF_AUX, 8'(TRG_FREE));
    expect_starts(0);
    u_far.set_done(1'b0);
    u_far.set_done(1'b1);
    expect_starts(1);
    u_far.set_done(1'b0);
    wr(ACM_OFF_CSR, 8'h03);
    wr(ACM_OFF_AUX, 8'(TRG_COMP));
    u_far.set_raw(1'b1);
    expect_starts(1);
    u_far.set_raw(1'b0);
    repeat (3) @(posedge ref_clk_i);
    wr(ACM_OFF_CSR, 8'h10);
    expect_starts(0);
    wr(ACM_OFF_CONV, 8'h00);
  endtask

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    test_reset_values();
    test_masks_and_pins();
    test_steering();
    test_irq_modes();
    test_triggers();
    finish_test();
  end
endmodule
